// >>> verilog/serial_tx_format_address_ctrl.sv
// Purpose: serial transmit buffer, addressing, priority and format
// Assumes: AXI4-Lite register access, one clock, DMA pulses on aclk
// Notes:   line input synchronised by two flops
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "serial_fmt_regs.svh"
module serial_tx_format_address_ctrl (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write
	input  wire logic [31:0]           awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// axi4-lite read
	input  wire logic [31:0]           araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// serial line
	input  wire logic                  rxd,
	output logic                       txd,
	// dma controller
	input  wire logic                  dma_rx_zero,
	input  wire logic                  dma_tx_zero,
	output serial_fmt_pkg::req_t       svc_req
);
	logic                    bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]              bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]             rdata_r, rdata_nxt;
	logic                    wr_go, rd_go, wr_hit, rd_hit;
	logic [`IDX_W-1:0]       widx, ridx;
	serial_fmt_pkg::fmt_t    fmt_r, fmt_nxt;
	serial_fmt_pkg::ctl_t    ctl_r, ctl_nxt;
	logic [7:0]              cmp_r, cmp_nxt, txbuf_r, txbuf_nxt;
	logic [7:0]              rxbuf_r, rxbuf_nxt;
	logic                    txfull_r, txfull_nxt, cd_r, cd_nxt;
	logic [15:0]             baud_r, baud_nxt, div_r, div_nxt;
	logic [9:0]              stat_r, stat_nxt, stat_set;
	logic                    tick;
	logic [4:0]              bit_last;
	logic [3:0]              len;
	logic [3:0]              nbits;
	serial_fmt_pkg::tx_state_t tx_st_r, tx_st_nxt;
	logic [4:0]              tx_sub_r, tx_sub_nxt;
	logic [5:0]              tx_cnt_r, tx_cnt_nxt, stop_ticks;
	logic [11:0]             tx_sh_r, tx_sh_nxt;
	logic                    txd_r, txd_nxt, tx_bit_end;
	logic                    ev_load, ev_txdone;
	serial_fmt_pkg::rx_state_t rx_st_r, rx_st_nxt;
	logic                    rx_s1_r, rx_s2_r;
	logic [4:0]              rx_sub_r, rx_sub_nxt;
	logic [3:0]              rx_cnt_r, rx_cnt_nxt;
	logic [11:0]             rx_sh_r, rx_sh_nxt;
	logic                    accept_r, accept_nxt, aftbrk_r, aftbrk_nxt;
	logic                    word_done;
	logic [7:0]              rx_data;
	logic                    rx_par, rx_nine, rx_stop, rx_brk;
	logic                    match, cand, hit, store;
	serial_fmt_pkg::req_t    req_r, req_nxt;
	logic                    tx_empty, rx_dreq, tx_dreq, rx_ireq, tx_ireq;

	// frame: start, data, parity, ninth bit; stop sent separately
	function automatic logic [11:0] build(input logic [7:0] d,
		input serial_fmt_pkg::fmt_t f, input logic nine);
		logic [11:0] fr;
		logic [3:0]  pos;
		logic [7:0]  dm;
		fr  = 12'hfff;
		dm  = 8'h00;
		pos = 4'd1;
		fr[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < 32'(f.word_length) + 5) begin
				fr[pos] = d[i];
				dm[i]   = d[i];
				pos     = pos + 4'd1;
			end
		end
		if (f.parity_enable) begin
			fr[pos] = ^dm ^ ~f.parity_type;
			pos     = pos + 4'd1;
		end
		if (f.address_bit_enable)
			fr[pos] = nine;
		return fr;
	endfunction

	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = rd_go;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;
	assign txd     = txd_r;
	assign svc_req = req_r;

	// bus handshake: write takes address and data together
	always_comb begin
		wr_go  = awvalid & wvalid & ~bvalid_r;
		rd_go  = arvalid & ~rvalid_r;
		widx   = awaddr[`IDX_W+1:2];
		ridx   = araddr[`IDX_W+1:2];
		wr_hit = (awaddr[31:`IDX_W+2] == '0) &&
			(widx == `IDX_CMP || widx == `IDX_STATUS ||
			widx == `IDX_TXBUF || widx == `IDX_CTL ||
			widx == `IDX_FMT || widx == `IDX_CLKCFG ||
			widx == `IDX_BAUD);
		rd_hit = (araddr[31:`IDX_W+2] == '0) &&
			(ridx == `IDX_CMP || ridx == `IDX_STATUS ||
			ridx == `IDX_TXBUF || ridx == `IDX_CTL ||
			ridx == `IDX_FMT || ridx == `IDX_CLKCFG ||
			ridx == `IDX_BAUD);
		bvalid_nxt = bvalid_r & ~bready;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r & ~rready;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			rdata_nxt  = 32'h0;
			unique case (1'b1)
				ridx == `IDX_CMP:    rdata_nxt[7:0] = cmp_r;
				ridx == `IDX_STATUS: rdata_nxt[9:0] = stat_r;
				// shared index: reads return the receive buffer
				ridx == `IDX_TXBUF:  rdata_nxt[7:0] = rxbuf_r;
				ridx == `IDX_CTL:    rdata_nxt[7:0] = ctl_r;
				ridx == `IDX_FMT:    rdata_nxt[7:0] = fmt_r;
				ridx == `IDX_CLKCFG: rdata_nxt[0]   = cd_r;
				ridx == `IDX_BAUD:   rdata_nxt[15:0] = baud_r;
				default:             rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= `RESP_OKAY;
			rdata_r  <= 32'h0;
		end else begin
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r  <= rresp_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// register file, status flags and bit clock
	always_comb begin
		fmt_nxt   = fmt_r;
		ctl_nxt   = ctl_r;
		cmp_nxt   = cmp_r;
		txbuf_nxt = txbuf_r;
		txfull_nxt = txfull_r;
		cd_nxt    = cd_r;
		baud_nxt  = baud_r;
		stat_nxt  = stat_r;
		rxbuf_nxt = rxbuf_r;
		div_nxt   = div_r;
		tick      = 1'b0;
		if (baud_r > 16'h0001) begin
			if (div_r == 16'h0000) begin
				tick    = 1'b1;
				div_nxt = baud_r - 16'h0001;
			end else begin
				div_nxt = div_r - 16'h0001;
			end
		end
		stat_set = 10'h000;
		stat_set[`ST_TX_BUFFER_EMPTY] = ev_load;
		stat_set[`ST_TX_SHIFT_EMPTY] = ev_txdone;
		stat_set[`ST_RECEIVED_DATA_PENDING]  = store;
		stat_set[`ST_OE]    = store & stat_r[`ST_RECEIVED_DATA_PENDING];
		stat_set[`ST_BRK]   = word_done & rx_brk;
		stat_set[`ST_ADDR]  = word_done & ~rx_brk & hit;
		stat_set[`ST_PE]    = word_done & ~rx_brk &
			fmt_r.parity_enable & (rx_par !=
			(^(rx_sh_nxt[7:0] & ~(8'hff << len)) ^
			~fmt_r.parity_type));
		stat_set[`ST_FE]    = word_done & ~rx_brk & ~rx_stop;
		stat_set[`ST_RXEOB] = dma_rx_zero;
		stat_set[`ST_TXEOB] = dma_tx_zero;
		if (store)
			rxbuf_nxt = rx_data;
		if (ev_load)
			txfull_nxt = 1'b0;
		if (ev_load)
			ctl_nxt.set_address_bit = 1'b0;
		// receive mask cleared at count zero
		if (dma_rx_zero)
			ctl_nxt.rx_dma_mask = 1'b0;
		// transmit mask cleared at count zero
		if (dma_tx_zero)
			ctl_nxt.tx_dma_mask = 1'b0;
		if (wr_go && wstrb[0]) begin
			unique case (1'b1)
				widx == `IDX_CMP:    cmp_nxt = wdata[7:0];
				widx == `IDX_STATUS: stat_nxt = stat_r & wdata[9:0];
				widx == `IDX_TXBUF: begin
					txbuf_nxt  = wdata[7:0];
					txfull_nxt = 1'b1;
					stat_nxt[`ST_TX_BUFFER_EMPTY] = 1'b0;
					stat_nxt[`ST_TX_SHIFT_EMPTY] = 1'b0;
				end
				widx == `IDX_CTL:    ctl_nxt = wdata[7:0];
				widx == `IDX_FMT:    fmt_nxt = wdata[7:0];
				widx == `IDX_CLKCFG: cd_nxt = wdata[0];
				widx == `IDX_BAUD:   baud_nxt[7:0] = wdata[7:0];
				default:             cmp_nxt = cmp_r;
			endcase
		end
		if (wr_go && wstrb[1] && widx == `IDX_BAUD)
			baud_nxt[15:8] = wdata[15:8];
		// hardware set wins over software clear
		stat_nxt = stat_nxt | stat_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fmt_r    <= `FMT_RST;
			ctl_r    <= `CTL_RST;
			cmp_r    <= `CMP_RST;
			txbuf_r  <= 8'h00;
			txfull_r <= 1'b0;
			cd_r     <= 1'b0;
			baud_r   <= `BAUD_RST;
			div_r    <= 16'h0000;
			stat_r   <= `ST_RST;
			rxbuf_r  <= 8'hff;
		end else begin
			fmt_r    <= fmt_nxt;
			ctl_r    <= ctl_nxt;
			cmp_r    <= cmp_nxt;
			txbuf_r  <= txbuf_nxt;
			txfull_r <= txfull_nxt;
			cd_r     <= cd_nxt;
			baud_r   <= baud_nxt;
			div_r    <= div_nxt;
			stat_r   <= stat_nxt;
			rxbuf_r  <= rxbuf_nxt;
		end
	end

	// character format shared by both directions
	always_comb begin
		bit_last = cd_r ? 5'd0 : `TICKS_16X - 5'd1;
		len   = 4'd5 + {2'b00, fmt_r.word_length};
		nbits = 4'd1 + len + {3'b000, fmt_r.parity_enable} +
			{3'b000, fmt_r.address_bit_enable};
		if (cd_r)
			unique case ({fmt_r.stop_sel_hi, fmt_r.stop_sel_lo})
				2'b00:   stop_ticks = 6'd1;
				2'b11:   stop_ticks = 6'd3;
				default: stop_ticks = 6'd2;
			endcase
		else
			stop_ticks = `STOP_UNIT_16X * (6'd2 +
				{4'b0000, fmt_r.stop_sel_hi, fmt_r.stop_sel_lo});
	end

	// transmitter
	always_comb begin
		tx_st_nxt  = tx_st_r;
		tx_sub_nxt = tx_sub_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_sh_nxt  = tx_sh_r;
		txd_nxt    = txd_r;
		ev_load    = 1'b0;
		ev_txdone  = 1'b0;
		tx_bit_end = tick && (tx_sub_r == bit_last);
		if (tick)
			tx_sub_nxt = tx_bit_end ? 5'd0 : tx_sub_r + 5'd1;
		unique case (tx_st_r)
			serial_fmt_pkg::TX_IDLE: begin
				txd_nxt    = 1'b1;
				tx_sub_nxt = 5'd0;
				if (txfull_r) begin
					tx_sh_nxt = build(txbuf_r, fmt_r,
						ctl_r.set_address_bit);
					tx_cnt_nxt = {2'b00, nbits};
					txd_nxt    = 1'b0;
					ev_load    = 1'b1;
					tx_st_nxt  = serial_fmt_pkg::TX_SHIFT;
				end else if (ctl_r.set_break) begin
					tx_cnt_nxt = {2'b00, nbits} + 6'd1;
					txd_nxt    = 1'b0;
					tx_st_nxt  = serial_fmt_pkg::TX_BRK;
				end
			end
			serial_fmt_pkg::TX_SHIFT: begin
				if (tx_bit_end) begin
					tx_sh_nxt  = {1'b1, tx_sh_r[11:1]};
					tx_cnt_nxt = tx_cnt_r - 6'd1;
					txd_nxt    = tx_sh_r[1];
					if (tx_cnt_r == 6'd1) begin
						txd_nxt    = 1'b1;
						tx_cnt_nxt = stop_ticks;
						tx_st_nxt  = serial_fmt_pkg::TX_STOP;
					end
				end
			end
			serial_fmt_pkg::TX_STOP: begin
				if (tick) begin
					tx_cnt_nxt = tx_cnt_r - 6'd1;
					if (tx_cnt_r == 6'd1) begin
						ev_txdone = ~txfull_r;
						tx_st_nxt = serial_fmt_pkg::TX_IDLE;
					end
				end
			end
			serial_fmt_pkg::TX_BRK: begin
				// low for a word and while set
				txd_nxt = 1'b0;
				if (tx_bit_end) begin
					if (tx_cnt_r != 6'd0)
						tx_cnt_nxt = tx_cnt_r - 6'd1;
					else if (!ctl_r.set_break) begin
						txd_nxt   = 1'b1;
						tx_st_nxt = serial_fmt_pkg::TX_MARK;
					end
				end
			end
			serial_fmt_pkg::TX_MARK: begin
				// one tick high ends the break
				txd_nxt = 1'b1;
				if (tick)
					tx_st_nxt = serial_fmt_pkg::TX_IDLE;
			end
			default: tx_st_nxt = serial_fmt_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r  <= serial_fmt_pkg::TX_IDLE;
			tx_sub_r <= 5'd0;
			tx_cnt_r <= 6'd0;
			tx_sh_r  <= 12'hfff;
			txd_r    <= 1'b1;
		end else begin
			tx_st_r  <= tx_st_nxt;
			tx_sub_r <= tx_sub_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_sh_r  <= tx_sh_nxt;
			txd_r    <= txd_nxt;
		end
	end

	// receiver and address decode
	always_comb begin
		rx_st_nxt  = rx_st_r;
		rx_sub_nxt = rx_sub_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_sh_nxt  = rx_sh_r;
		word_done  = 1'b0;
		unique case (rx_st_r)
			serial_fmt_pkg::RX_IDLE: begin
				rx_sub_nxt = 5'd0;
				rx_cnt_nxt = 4'd0;
				if (tick && !rx_s2_r)
					rx_st_nxt = cd_r ? serial_fmt_pkg::RX_BITS :
						serial_fmt_pkg::RX_START;
			end
			serial_fmt_pkg::RX_START: begin
				// recheck start bit at its middle
				if (tick) begin
					rx_sub_nxt = rx_sub_r + 5'd1;
					if (rx_sub_r == `HALF_16X) begin
						rx_sub_nxt = 5'd0;
						rx_st_nxt  = rx_s2_r ?
							serial_fmt_pkg::RX_IDLE :
							serial_fmt_pkg::RX_BITS;
					end
				end
			end
			serial_fmt_pkg::RX_BITS: begin
				if (tick) begin
					rx_sub_nxt = rx_sub_r + 5'd1;
					if (rx_sub_r == bit_last) begin
						rx_sub_nxt = 5'd0;
						rx_sh_nxt[rx_cnt_r] = rx_s2_r;
						rx_cnt_nxt = rx_cnt_r + 4'd1;
						if (rx_cnt_r == nbits - 4'd1) begin
							word_done = 1'b1;
							rx_st_nxt = serial_fmt_pkg::RX_WAIT;
						end
					end
				end
			end
			serial_fmt_pkg::RX_WAIT: begin
				if (rx_s2_r)
					rx_st_nxt = serial_fmt_pkg::RX_IDLE;
			end
			default: rx_st_nxt = serial_fmt_pkg::RX_IDLE;
		endcase
		// data unused high bits read as ones
		rx_data = 8'hff;
		for (int i = 0; i < 8; i++)
			if (i < 32'(len))
				rx_data[i] = rx_sh_nxt[i];
		rx_par  = rx_sh_nxt[len];
		rx_nine = rx_sh_nxt[len + {3'b000, fmt_r.parity_enable}];
		rx_stop = rx_sh_nxt[nbits - 4'd1];
		rx_brk  = ((rx_sh_nxt & ((12'h001 << nbits) - 12'h001))
			== 12'h000);
		match   = (rx_data == cmp_r);
		unique case ({ctl_r.address_enable, fmt_r.addr_sel})
			2'b00: begin cand = rx_nine; hit = rx_nine; end
			2'b01: begin cand = 1'b0; hit = match; end
			// match with ninth bit set
			2'b10: begin cand = rx_nine; hit = match & rx_nine; end
			default: begin cand = aftbrk_r; hit = aftbrk_r & match; end
		endcase
		if (!fmt_r.address_bit_enable && !fmt_r.addr_sel &&
			!ctl_r.address_enable) begin
			cand = 1'b0;
			hit  = 1'b0;
		end
		accept_nxt = accept_r;
		aftbrk_nxt = aftbrk_r;
		store      = 1'b0;
		if (word_done) begin
			aftbrk_nxt = rx_brk;
			if (!rx_brk) begin
				if (cand)
					accept_nxt = hit;
				store = ~cand & (accept_r | fmt_r.addr_sel &
					~ctl_r.address_enable | ~fmt_r.address_bit_enable &
					~fmt_r.addr_sel & ~ctl_r.address_enable);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_s1_r  <= 1'b1;
			rx_s2_r  <= 1'b1;
			rx_st_r  <= serial_fmt_pkg::RX_IDLE;
			rx_sub_r <= 5'd0;
			rx_cnt_r <= 4'd0;
			rx_sh_r  <= 12'hfff;
			accept_r <= 1'b0;
			aftbrk_r <= 1'b0;
		end else begin
			rx_s1_r  <= rxd;
			rx_s2_r  <= rx_s1_r;
			rx_st_r  <= rx_st_nxt;
			rx_sub_r <= rx_sub_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_sh_r  <= rx_sh_nxt;
			accept_r <= accept_nxt;
			aftbrk_r <= aftbrk_nxt;
		end
	end

	// request selection
	always_comb begin
		tx_empty = stat_r[`ST_TX_BUFFER_EMPTY] | stat_r[`ST_TX_SHIFT_EMPTY];
		// data pending to DMA or interrupt
		rx_dreq  = stat_r[`ST_RECEIVED_DATA_PENDING] & ctl_r.rx_dma_mask;
		rx_ireq  = stat_r[`ST_RECEIVED_DATA_PENDING] & ~ctl_r.rx_dma_mask |
			stat_r[`ST_RXEOB] | stat_r[`ST_ADDR];
		tx_dreq  = tx_empty & ctl_r.tx_dma_mask;
		tx_ireq  = tx_empty & ~ctl_r.tx_dma_mask | stat_r[`ST_TXEOB];
		req_nxt.level = ctl_r.priority_level;
		req_nxt.sel = rx_dreq ? 4'b0001 : tx_dreq ? 4'b0010 :
			rx_ireq ? 4'b0100 : tx_ireq ? 4'b1000 : 4'b0000;
		req_nxt.valid = (req_nxt.sel != 4'b0000) &&
			(ctl_r.priority_level != 3'h7);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			req_r <= '0;
		else
			req_r <= req_nxt;
	end
endmodule

// >>> verilog/serial_fmt_regs.svh
// Purpose: register indices, field positions, reset values, counts
// Assumes: byte address is four times the register index
// Notes:   indices are word numbers on the AXI4-Lite bus
`ifndef SERIAL_FMT_REGS_SVH
`define SERIAL_FMT_REGS_SVH
`define IDX_W          10
`define IDX_CMP        10'h0f5
`define IDX_STATUS     10'h0f7
`define IDX_TXBUF      10'h0f8
`define IDX_CTL        10'h0f9
`define IDX_FMT        10'h0fa
`define IDX_CLKCFG     10'h0fb
`define IDX_BAUD       10'h0fc
`define CTL_RST        8'h07
`define FMT_RST        8'h03
`define CMP_RST        8'h00
`define BAUD_RST       16'h0002
`define ST_TX_SHIFT_EMPTY       0
`define ST_TX_BUFFER_EMPTY       1
`define ST_RECEIVED_DATA_PENDING        2
`define ST_BRK         3
`define ST_ADDR        4
`define ST_PE          5
`define ST_FE          6
`define ST_OE          7
`define ST_TXEOB       8
`define ST_RXEOB       9
`define ST_RST         10'h003
`define TICKS_16X      5'd16
`define HALF_16X       5'd7
`define STOP_UNIT_16X  6'd8
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// >>> verilog/serial_fmt_pkg.sv
// Purpose: types of the serial format and addressing block
// Assumes: nothing
// Notes:   struct layouts follow the register bit order
package serial_fmt_pkg;
	typedef struct packed {
		logic       addr_sel;
		logic       parity_type;
		logic       parity_enable;
		logic       address_bit_enable;
		logic       stop_sel_hi;
		logic       stop_sel_lo;
		logic [1:0] word_length;
	} fmt_t;
	typedef struct packed {
		logic       address_enable;
		logic       set_break;
		logic       set_address_bit;
		logic       rx_dma_mask;
		logic       tx_dma_mask;
		logic [2:0] priority_level;
	} ctl_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] sel;
		logic [2:0] level;
	} req_t;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_SHIFT = 5'b00010,
		TX_STOP  = 5'b00100,
		TX_BRK   = 5'b01000,
		TX_MARK  = 5'b10000
	} tx_state_t;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_BITS  = 4'b0100,
		RX_WAIT  = 4'b1000
	} rx_state_t;
endpackage

// >>> verif/serial_fmt_asserts.sv
// Purpose: port checks of the serial format block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into the design top below
`timescale 1ns/10ps
module serial_fmt_asserts (
	// clock and reset
	input wire logic			aclk,
	input wire logic			aresetn,
	// register bus
	input wire logic [31:0]			awaddr,
	input wire logic			awvalid,
	input wire logic			awready,
	input wire logic			wvalid,
	input wire logic			wready,
	input wire logic [1:0]			bresp,
	input wire logic			bvalid,
	input wire logic			bready,
	input wire logic			arvalid,
	input wire logic			arready,
	input wire logic [31:0]			rdata,
	input wire logic			rvalid,
	input wire logic			rready,
	// dma and service
	input wire logic			dma_rx_zero,
	input wire logic			dma_tx_zero,
	input wire serial_fmt_pkg::req_t	svc_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_pair_a: assert property (awready == (awvalid && wvalid && !bvalid)
		&& wready == awready) else $error("write accept wrong");
	b_next_a: assert property (awready |=> bvalid)
		else $error("write answer late");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	bad_addr_a: assert property (awready && (awaddr[31:12] != 20'h0 ||
		awaddr[11:2] == 10'h3ff) |=> bresp == 2'b10)
		else $error("unmapped write not refused");
	ar_take_a: assert property ((arready == (arvalid && !rvalid)) and
		(arready |=> rvalid)) else $error("read accept wrong");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	prio_level_a: assert property (
		svc_req.valid == (svc_req.sel != 4'h0 && svc_req.level != 3'h7))
		else $error("service valid wrong");
	prio_order_a: assert property ($onehot0(svc_req.sel))
		else $error("more than one service");
	tx_eob_a: assert property (dma_tx_zero |-> ##2 !svc_req.sel[1])
		else $error("tx dma after count zero");
	rx_eob_a: assert property (dma_rx_zero |-> ##2 !svc_req.sel[0])
		else $error("rx dma after count zero");
endmodule
bind serial_tx_format_address_ctrl serial_fmt_asserts chk_i (
	.aclk        (aclk),
	.aresetn     (aresetn),
	.awaddr      (awaddr),
	.awvalid     (awvalid),
	.awready     (awready),
	.wvalid      (wvalid),
	.wready      (wready),
	.bresp       (bresp),
	.bvalid      (bvalid),
	.bready      (bready),
	.arvalid     (arvalid),
	.arready     (arready),
	.rdata       (rdata),
	.rvalid      (rvalid),
	.rready      (rready),
	.dma_rx_zero (dma_rx_zero),
	.dma_tx_zero (dma_tx_zero),
	.svc_req     (svc_req)
);

// >>> verif/serial_line_model.sv
// Purpose: remote serial device on the line
// Assumes: bit time of BIT clocks, lsb first
// Notes:   line idles high between frames
`timescale 1ns/10ps
module serial_line_model #(parameter int BIT = 32) (
	// clock
	input wire logic	aclk,
	// serial line
	input wire logic	txd,
	output logic		rxd
);
	initial rxd = 1'b1;
	task send(input logic [15:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= fr[i];
			repeat (BIT) @(posedge aclk);
		end
		rxd <= 1'b1;
	endtask
	// unknown result when no start bit shows
	task grab(output logic [15:0] fr);
		int i;
		fr = 'x;
		for (i = 0; i < 4000 && txd !== 1'b0; i++)
			@(posedge aclk);
		if (i < 4000) begin
			repeat (BIT / 2) @(posedge aclk);
			for (int k = 0; k < 16; k++) begin
				fr[k] = txd;
				repeat (BIT) @(posedge aclk);
			end
		end
	endtask
endmodule

// >>> verif/serial_tx_format_address_ctrl_tb.sv
// Purpose: self-checking bench of the serial format block
// Assumes: 16X mode, tick every 2 clocks, 32 clocks a bit
// Notes:   frames sent and captured by the line model
`timescale 1ns/10ps
`include "serial_fmt_regs.svh"
module serial_tx_format_address_ctrl_tb;
	logic				aclk, aresetn, awvalid, wvalid, bready;
	logic				arvalid, rready, dma_rx_zero, dma_tx_zero;
	logic				rxd, txd, awready, wready, bvalid, arready, rvalid;
	logic [31:0]			awaddr, wdata, araddr, rdata, v;
	logic [3:0]			wstrb;
	logic [1:0]			bresp, rresp, rs;
	logic [15:0]			f, e;
	serial_fmt_pkg::req_t		svc_req;
	int				errors, total_checks, n;
	serial_tx_format_address_ctrl DUT (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.awaddr      (awaddr),
		.awvalid     (awvalid),
		.awready     (awready),
		.wdata       (wdata),
		.wstrb       (wstrb),
		.wvalid      (wvalid),
		.wready      (wready),
		.bresp       (bresp),
		.bvalid      (bvalid),
		.bready      (bready),
		.araddr      (araddr),
		.arvalid     (arvalid),
		.arready     (arready),
		.rdata       (rdata),
		.rresp       (rresp),
		.rvalid      (rvalid),
		.rready      (rready),
		.rxd         (rxd),
		.txd         (txd),
		.dma_rx_zero (dma_rx_zero),
		.dma_tx_zero (dma_tx_zero),
		.svc_req     (svc_req)
	);
	serial_line_model L (
		.aclk (aclk),
		.txd  (txd),
		.rxd  (rxd)
	);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task final_report(input int bad);
		errors = errors + bad;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
		total_checks++;
		if (got !== x) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, x, got);
		end
	endtask
	task wr(input logic [9:0] ix, input logic [31:0] d);
		int i;
		logic a, b;
		awaddr <= {20'h0, ix, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			a = awready;
			b = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (a) begin
				awvalid <= 1'b0;
				wvalid <= 1'b0;
			end
			if (b) break;
		end
		if (i == 40) final_report(1);
	endtask
	task rd(input logic [9:0] ix, output logic [31:0] d);
		int i;
		logic a, r;
		araddr <= {20'h0, ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			a = arready;
			r = rvalid;
			d = rdata;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
			if (r) break;
		end
		if (i == 40) final_report(1);
	endtask
	task rxf(input logic [7:0] d, input logic nine);
		L.send({5'h1f, 1'b1, nine, d, 1'b0}, 12);
		repeat (40) @(posedge aclk);
	endtask
	// capture a frame; no start bit ends the run
	task cap();
		L.grab(f);
		if (f[0] !== 1'b0) final_report(1);
	endtask
	task pulse(input logic rx);
		if (rx) dma_rx_zero <= 1'b1;
		else dma_tx_zero <= 1'b1;
		@(posedge aclk);
		dma_rx_zero <= 1'b0;
		dma_tx_zero <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{dma_rx_zero, dma_tx_zero} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		errors = 0;
		total_checks = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`IDX_CTL, v);
		chk("ctl", v, 32'h07);
		rd(`IDX_FMT, v);
		chk("fmt", v, 32'h03);
		wr(10'h3ff, 32'h0);
		chk("bresp", rs, 2'b10);
		for (int w = 0; w < 4; w++) begin
			wr(`IDX_FMT, w);
			wr(`IDX_TXBUF, 32'h1a);
			cap();
			e = 16'hfffe;
			for (int k = 0; k < w + 5; k++)
				e[k + 1] = 8'h1a >> k;
			chk("frame", f, e);
		end
		// 1X: start and eight zero bits, one tick of two clocks each
		wr(`IDX_CLKCFG, 32'h1);
		wr(`IDX_TXBUF, 32'h00);
		for (n = 0; n < 400 && txd !== 1'b0; n++)
			@(posedge aclk);
		for (n = 0; n < 400 && txd === 1'b0; n++)
			@(posedge aclk);
		chk("onex", n == 17 || n == 18, 1);
		if (n == 0 || n == 400) final_report(0);
		wr(`IDX_CLKCFG, 32'h0);
		rd(`IDX_STATUS, v);
		chk("txempty", v[1], 1'b1);
		wr(`IDX_FMT, 32'h73);
		wr(`IDX_CTL, 32'h27);
		wr(`IDX_TXBUF, 32'h03);
		cap();
		chk("even9", f, 16'hfc06);
		rd(`IDX_CTL, v);
		chk("sa_clr", v, 32'h07);
		wr(`IDX_FMT, 32'h33);
		wr(`IDX_TXBUF, 32'h03);
		cap();
		chk("odd", f, 16'hfa06);
		wr(`IDX_FMT, 32'h0b);
		wr(`IDX_TXBUF, 32'h0f);
		wr(`IDX_CTL, 32'h47);
		cap();
		chk("brk", f, 16'h061e);
		repeat (300) @(posedge aclk);
		chk("brk_on", txd, 1'b0);
		wr(`IDX_CTL, 32'h07);
		for (n = 0; n < 100 && txd !== 1'b1; n++)
			@(posedge aclk);
		chk("brk_end", n < 100, 1);
		if (n == 100) final_report(0);
		wr(`IDX_CTL, 32'h0b);
		repeat (2) @(posedge aclk);
		chk("txdma", svc_req, 8'h93);
		pulse(1'b0);
		chk("txirq", svc_req, 8'hc3);
		rd(`IDX_CTL, v);
		chk("txmask", v, 32'h03);
		wr(`IDX_CTL, 32'h13);
		pulse(1'b1);
		chk("rxeob", svc_req, 8'ha3);
		rd(`IDX_CTL, v);
		chk("rxmask", v, 32'h03);
		wr(`IDX_CTL, 32'h07);
		repeat (2) @(posedge aclk);
		chk("lvl7", svc_req.valid, 1'b0);
		wr(`IDX_CMP, 32'h41);
		for (int m = 0; m < 4; m++) begin
			wr(`IDX_FMT, m[0] ? 32'h93 : 32'h13);
			wr(`IDX_CTL, m[1] ? 32'h87 : 32'h07);
			wr(`IDX_STATUS, 32'h0);
			if (m == 3) L.send(16'hf800, 12);
			rxf(8'h41, 1'b1);
			rd(`IDX_STATUS, v);
			chk("addr", v[4], 1'b1);
			// character search keeps the found character
			if (m < 3) chk("store", v[2], m == 1);
		end
		wr(`IDX_FMT, 32'h13);
		wr(`IDX_CTL, 32'h87);
		wr(`IDX_STATUS, 32'h0);
		rxf(8'h41, 1'b0);
		rd(`IDX_STATUS, v);
		chk("nine0", v[4], 1'b0);
		rxf(8'h41, 1'b1);
		wr(`IDX_STATUS, 32'h0);
		rxf(8'h55, 1'b0);
		wr(`IDX_CTL, 32'h93);
		repeat (2) @(posedge aclk);
		chk("rxdma", svc_req, 8'h8b);
		rd(`IDX_TXBUF, v);
		chk("data", v[7:0], 8'h55);
		wr(`IDX_CTL, 32'h87);
		rxf(8'h40, 1'b1);
		rxf(8'h66, 1'b0);
		rd(`IDX_TXBUF, v);
		chk("discard", v[7:0], 8'h55);
		final_report(0);
	end
endmodule
